// ==== pll_hold_pkg.sv ====
// constants, field layouts and carriers for the pll holdover control bits
// assumes a register write/read port driven by the serial control port logic
// Operation
// [RL1] status readback disable bit set stops automatic refresh of the pll status register
// [RL2] comparator bit set: holdover uses measured lock pin voltage as prior lock
// [RL3] comparator bit clear: lock pin voltage ignored, prior lock taken as true
// [RL4] comparator output offered to reference watch and status pins when enabled
// [RL5] external holdover bit set: hold request pin controls holdover, internal disabled
// [RL6] internal holdover enabled only while holdover enable bit set; clear at reset
// [RL7] two-bit field selects channel divider 0 to 3 for external zero-delay feedback
// [RL8] doubler enable bit turns on reference clock doubler; clear at reset
package pll_hold_pkg;
   localparam logic [9:0] PLL_HOLD_OFS = 10'h01D;
   localparam logic [9:0] ZD_FB_OFS = 10'h01E;
   localparam logic [9:0] STATUS_OFS = 10'h01F;
   localparam logic [7:0] PLL_HOLD_RST = 8'h00;
   localparam logic [7:0] ZD_FB_RST = 8'h00;
   localparam int HOLD_EN_BIT = 0;
   localparam int EXT_HOLD_BIT = 1;
   localparam int LD_CMP_BIT = 3;
   localparam int STAT_DIS_BIT = 4;
   localparam int DOUBLER_BIT = 5;
   localparam int FB_SEL_LO = 3;
   localparam logic [7:0] PLL_HOLD_MASK = 8'hFB;
   localparam logic [7:0] ZD_FB_MASK = 8'h1F;

   typedef struct packed {
      logic hold_en;
      logic ext_hold;
      logic ld_cmp_en;
      logic stat_dis;
      logic doubler_en;
      logic [1:0] fb_sel;
   } cfg_s;

   typedef enum logic [1:0] {
      HOLD_AUTO = 2'b01,
      HOLD_EXT = 2'b10
   } hold_src_e;
endpackage

// ==== status_snap.sv ====
// pll status register snapshot, refreshed each cycle unless frozen
// assumes live status bits are synchronous to mclk
module status_snap #(
   parameter int W = 8
) (
   input wire logic mclk,
   input wire logic srst,
   input wire logic freeze,
   input wire logic [W-1:0] live,
   output logic [W-1:0] snap
);
   logic [W-1:0] snap_ff;
   logic [W-1:0] nxt_snap;

   // hold value while freeze is high
   always_comb
   begin
      nxt_snap = freeze ? snap_ff : live; // see [RL1]
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
         snap_ff <= '0;
      else
         snap_ff <= nxt_snap;
   end

   assign snap = snap_ff;
endmodule

// ==== pll_holdover_config_bits.sv ====
// configuration bits for doubler, status refresh, holdover and zero-delay feedback
// assumes reg_wr/reg_rd strobes and address from the serial port, all on mclk
module pll_holdover_config_bits (
   input wire logic mclk,
   input wire logic srst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [9:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic [7:0] pll_status_live,
   input wire logic lock_indicator_pin_cmp,
   input wire logic auto_hold_req,
   input wire logic hold_request_pin,
   output logic doubler_on,
   output logic prev_locked,
   output logic cmp_monitor_valid,
   output logic cmp_monitor,
   output logic holdover_enable,
   output logic holdover_request,
   output pll_hold_pkg::hold_src_e hold_src,
   output logic [1:0] fb_divider_sel,
   output pll_hold_pkg::cfg_s cfg
);
   logic [7:0] hold_reg_ff;
   logic [7:0] nxt_hold_reg;
   logic [7:0] zd_reg_ff;
   logic [7:0] nxt_zd_reg;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic [7:0] status_snap_q;

   // register writes, reserved bits stay zero
   always_comb
   begin
      nxt_hold_reg = hold_reg_ff;
      nxt_zd_reg = zd_reg_ff;
      if (reg_wr && reg_addr == pll_hold_pkg::PLL_HOLD_OFS)
         nxt_hold_reg = reg_wdata & pll_hold_pkg::PLL_HOLD_MASK;
      else if (reg_wr && reg_addr == pll_hold_pkg::ZD_FB_OFS)
         nxt_zd_reg = reg_wdata & pll_hold_pkg::ZD_FB_MASK;
   end

   // read data mux, unmapped reads zero
   always_comb
   begin
      nxt_rdata = rdata_ff;
      if (reg_rd)
      begin
         if (reg_addr == pll_hold_pkg::PLL_HOLD_OFS)
            nxt_rdata = hold_reg_ff;
         else if (reg_addr == pll_hold_pkg::ZD_FB_OFS)
            nxt_rdata = zd_reg_ff;
         else if (reg_addr == pll_hold_pkg::STATUS_OFS)
            nxt_rdata = status_snap_q;
         else
            nxt_rdata = 8'h00;
      end
   end

   always_ff @(posedge mclk)
   begin
      if (srst)
      begin
         hold_reg_ff <= pll_hold_pkg::PLL_HOLD_RST; // see [RL6] see [RL8]
         zd_reg_ff <= pll_hold_pkg::ZD_FB_RST;
         rdata_ff <= 8'h00;
      end
      else
      begin
         hold_reg_ff <= nxt_hold_reg;
         zd_reg_ff <= nxt_zd_reg;
         rdata_ff <= nxt_rdata;
      end
   end

   assign reg_rdata = rdata_ff;

   // status register snapshot, frozen by the readback disable bit
   status_snap #(.W(8)) u_snap (
      .mclk(mclk),
      .srst(srst),
      .freeze(hold_reg_ff[pll_hold_pkg::STAT_DIS_BIT]), // see [RL1]
      .live(pll_status_live),
      .snap(status_snap_q)
   );

   // decoded configuration
   always_comb
   begin
      cfg.hold_en = hold_reg_ff[pll_hold_pkg::HOLD_EN_BIT];
      cfg.ext_hold = hold_reg_ff[pll_hold_pkg::EXT_HOLD_BIT];
      cfg.ld_cmp_en = hold_reg_ff[pll_hold_pkg::LD_CMP_BIT];
      cfg.stat_dis = hold_reg_ff[pll_hold_pkg::STAT_DIS_BIT];
      cfg.doubler_en = hold_reg_ff[pll_hold_pkg::DOUBLER_BIT];
      cfg.fb_sel = zd_reg_ff[pll_hold_pkg::FB_SEL_LO +: 2];
   end

   assign doubler_on = cfg.doubler_en; // see [RL8]
   assign fb_divider_sel = cfg.fb_sel; // see [RL7]
   assign holdover_enable = cfg.hold_en; // see [RL6]

   // prior-lock input: comparator or forced true
   assign prev_locked = cfg.ld_cmp_en ? lock_indicator_pin_cmp : 1'b1; // see [RL2] see [RL3]

   // comparator monitor toward reference watch and status pins
   assign cmp_monitor_valid = cfg.ld_cmp_en; // see [RL4]
   assign cmp_monitor = cfg.ld_cmp_en & lock_indicator_pin_cmp; // see [RL4]

   // holdover source and request
   assign hold_src = cfg.ext_hold ? pll_hold_pkg::HOLD_EXT : pll_hold_pkg::HOLD_AUTO; // see [RL5]
   assign holdover_request = cfg.ext_hold ? hold_request_pin
                           : (cfg.hold_en & auto_hold_req & prev_locked); // see [RL5] see [RL6]

   // write to holdover register lands next cycle
   wr_hold_a: assert property (@(posedge mclk) disable iff (srst) // see [RL6]
      reg_wr && reg_addr == pll_hold_pkg::PLL_HOLD_OFS |=>
      holdover_enable == $past(reg_wdata[0]))
      else $error("holdover enable not written");

   dbl_wr_a: assert property (@(posedge mclk) disable iff (srst) // see [RL8]
      reg_wr && reg_addr == pll_hold_pkg::PLL_HOLD_OFS |=>
      doubler_on == $past(reg_wdata[pll_hold_pkg::DOUBLER_BIT]))
      else $error("doubler enable not written");

   cmp_wr_a: assert property (@(posedge mclk) disable iff (srst) // see [RL2]
      reg_wr && reg_addr == pll_hold_pkg::PLL_HOLD_OFS |=>
      cfg.ld_cmp_en == $past(reg_wdata[pll_hold_pkg::LD_CMP_BIT]))
      else $error("comparator enable not written");

   ext_wr_a: assert property (@(posedge mclk) disable iff (srst) // see [RL5]
      reg_wr && reg_addr == pll_hold_pkg::PLL_HOLD_OFS |=>
      cfg.ext_hold == $past(reg_wdata[pll_hold_pkg::EXT_HOLD_BIT]))
      else $error("external holdover bit not written");

   stat_wr_a: assert property (@(posedge mclk) disable iff (srst) // see [RL1]
      reg_wr && reg_addr == pll_hold_pkg::PLL_HOLD_OFS |=>
      cfg.stat_dis == $past(reg_wdata[pll_hold_pkg::STAT_DIS_BIT]))
      else $error("readback disable bit not written");

   // registers keep their value between writes, reserved bits stay zero
   hold_keep_a: assert property (@(posedge mclk) disable iff (srst) // see [RL6]
      !(reg_wr && reg_addr == pll_hold_pkg::PLL_HOLD_OFS) |=> $stable(hold_reg_ff))
      else $error("holdover register changed without write");

   fb_keep_a: assert property (@(posedge mclk) disable iff (srst) // see [RL7]
      !(reg_wr && reg_addr == pll_hold_pkg::ZD_FB_OFS) |=> $stable(fb_divider_sel))
      else $error("divider select changed without write");

   rsv_zero_a: assert property (@(posedge mclk) disable iff (srst) // see [RL7]
      hold_reg_ff[2] == 1'b0 && zd_reg_ff[7:5] == 3'h0)
      else $error("reserved bit set");

   // values after reset
   hold_rst_a: assert property (@(posedge mclk) // see [RL6]
      srst |=> hold_reg_ff == pll_hold_pkg::PLL_HOLD_RST
      && zd_reg_ff == pll_hold_pkg::ZD_FB_RST)
      else $error("register not cleared by reset");

   dbl_a: assert property (@(posedge mclk) // see [RL8]
      srst |=> !doubler_on)
      else $error("doubler on after reset");

   rdata_rst_a: assert property (@(posedge mclk) // see [RL1]
      srst |=> reg_rdata == 8'h00 && status_snap_q == 8'h00)
      else $error("read data or snapshot not cleared by reset");

   // read data follows the addressed register, old value on a same-cycle write
   rd_hold_a: assert property (@(posedge mclk) disable iff (srst) // see [RL6]
      reg_rd && reg_addr == pll_hold_pkg::PLL_HOLD_OFS |=> reg_rdata == $past(hold_reg_ff))
      else $error("holdover register read wrong");

   rd_zd_a: assert property (@(posedge mclk) disable iff (srst) // see [RL7]
      reg_rd && reg_addr == pll_hold_pkg::ZD_FB_OFS |=> reg_rdata == $past(zd_reg_ff))
      else $error("feedback register read wrong");

   rd_stat_a: assert property (@(posedge mclk) disable iff (srst) // see [RL1]
      reg_rd && reg_addr == pll_hold_pkg::STATUS_OFS |=> reg_rdata == $past(status_snap_q))
      else $error("status register read wrong");

   rd_keep_a: assert property (@(posedge mclk) disable iff (srst) // see [RL1]
      !reg_rd |=> $stable(reg_rdata))
      else $error("read data changed without read");

   rd_unmap_a: assert property (@(posedge mclk) disable iff (srst) // see [RL7]
      reg_rd && reg_addr != pll_hold_pkg::PLL_HOLD_OFS && reg_addr != pll_hold_pkg::ZD_FB_OFS
      && reg_addr != pll_hold_pkg::STATUS_OFS |=> reg_rdata == 8'h00)
      else $error("unmapped read not zero");

   // status refresh and freeze
   stat_freeze_a: assert property (@(posedge mclk) disable iff (srst) // see [RL1]
      hold_reg_ff[4] && $past(hold_reg_ff[4]) |-> $stable(status_snap_q))
      else $error("status refreshed while disabled");

   stat_live_a: assert property (@(posedge mclk) disable iff (srst) // see [RL1]
      !hold_reg_ff[4] |=> status_snap_q == $past(pll_status_live))
      else $error("status not refreshed");

   // lock comparator use and monitor
   cmp_used_a: assert property (@(posedge mclk) disable iff (srst) // see [RL2]
      cfg.ld_cmp_en |-> prev_locked == lock_indicator_pin_cmp)
      else $error("comparator not used");

   cmp_ignored_a: assert property (@(posedge mclk) disable iff (srst) // see [RL3]
      !cfg.ld_cmp_en |-> prev_locked)
      else $error("prior lock not forced true");

   cmp_mon_a: assert property (@(posedge mclk) disable iff (srst) // see [RL4]
      cmp_monitor_valid |-> cmp_monitor == lock_indicator_pin_cmp)
      else $error("monitor wrong");

   mon_off_a: assert property (@(posedge mclk) disable iff (srst) // see [RL4]
      !cmp_monitor_valid |-> !cmp_monitor)
      else $error("monitor active while comparator off");

   // holdover source and request
   ext_hold_a: assert property (@(posedge mclk) disable iff (srst) // see [RL5]
      cfg.ext_hold |-> holdover_request == hold_request_pin && hold_src == pll_hold_pkg::HOLD_EXT)
      else $error("external hold not followed");

   auto_src_a: assert property (@(posedge mclk) disable iff (srst) // see [RL5]
      !cfg.ext_hold |-> hold_src == pll_hold_pkg::HOLD_AUTO)
      else $error("automatic holdover source not selected");

   int_off_a: assert property (@(posedge mclk) disable iff (srst) // see [RL6]
      !cfg.ext_hold && !holdover_enable |-> !holdover_request)
      else $error("holdover while disabled");

   auto_gate_a: assert property (@(posedge mclk) disable iff (srst) // see [RL6]
      !cfg.ext_hold && holdover_enable && auto_hold_req && prev_locked |-> holdover_request)
      else $error("automatic holdover request lost");

   // feedback divider select
   fb_sel_a: assert property (@(posedge mclk) disable iff (srst) // see [RL7]
      reg_wr && reg_addr == pll_hold_pkg::ZD_FB_OFS |=> fb_divider_sel == $past(reg_wdata[4:3]))
      else $error("divider select wrong");
endmodule

// ==== tb.sv ====
// self-checking bench for the pll holdover configuration bits
// assumes the package and design files are compiled first
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   logic mclk = 1'b0;
   logic srst = 1'b1;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [9:0] reg_addr = 10'h000;
   logic [7:0] reg_wdata = 8'h00;
   logic [7:0] live = 8'h00;
   logic cmp = 1'b0;
   logic areq = 1'b0;
   logic pin = 1'b0;
   logic [7:0] reg_rdata;
   logic [7:0] v;
   logic dbl, prev, mval, mon, hen, hreq;
   pll_hold_pkg::hold_src_e src;
   logic [1:0] fsel;
   pll_hold_pkg::cfg_s cfg_q;
   int n_errors = 0;
   int tests_run = 0;
   // clock, 8 ns period
   initial forever #4 mclk = ~mclk;
   pll_holdover_config_bits i_dut (.mclk(mclk), .srst(srst), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
      .pll_status_live(live), .lock_indicator_pin_cmp(cmp), .auto_hold_req(areq),
      .hold_request_pin(pin), .doubler_on(dbl), .prev_locked(prev),
      .cmp_monitor_valid(mval), .cmp_monitor(mon), .holdover_enable(hen),
      .holdover_request(hreq), .hold_src(src), .fb_divider_sel(fsel), .cfg(cfg_q));
   // compare one byte
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         n_errors++;
         $display("unexpected at %0t: got %h exp %h", $time, got, exp);
      end
   endtask
   // one-cycle write strobe
   task automatic wr(input logic [9:0] a, input logic [7:0] d);
      @(posedge mclk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      #1;
   endtask
   // one-cycle read strobe, data after the taking edge
   task automatic rd(input logic [9:0] a);
      @(posedge mclk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge mclk);
      reg_rd <= 1'b0;
      #1;
      v = reg_rdata;
   endtask
   // drive comparator, auto request and hold pin
   task automatic pins(input logic c, input logic a, input logic p);
      @(posedge mclk);
      cmp <= c;
      areq <= a;
      pin <= p;
      #1;
   endtask
   // reset values, reserved bits, unmapped read
   task automatic t_regs;
      rd(pll_hold_pkg::PLL_HOLD_OFS);
      chk(v, 8'h00);
      chk({7'h00, dbl}, 8'h00);
      rd(pll_hold_pkg::ZD_FB_OFS);
      chk(v, 8'h00);
      wr(pll_hold_pkg::ZD_FB_OFS, 8'hFF);
      rd(pll_hold_pkg::ZD_FB_OFS);
      chk(v, 8'h1F);
      wr(pll_hold_pkg::PLL_HOLD_OFS, 8'hFF);
      rd(pll_hold_pkg::PLL_HOLD_OFS);
      chk(v, 8'hFB);
      wr(pll_hold_pkg::STATUS_OFS, 8'h00);
      wr(10'h100, 8'h00);
      rd(pll_hold_pkg::PLL_HOLD_OFS);
      chk(v, 8'hFB);
      rd(10'h100);
      chk(v, 8'h00);
      $display("t_regs done");
   endtask
   // holdover source, enable, doubler and lock comparator
   task automatic t_hold;
      wr(pll_hold_pkg::PLL_HOLD_OFS, 8'h21);
      pins(1'b0, 1'b1, 1'b0);
      chk({7'h00, dbl}, 8'h01);
      chk({3'h0, cfg_q[6:2]}, 8'h11);
      chk({6'h00, src}, 8'h01);
      chk({5'h00, prev, mon, hreq}, 8'h05);
      wr(pll_hold_pkg::PLL_HOLD_OFS, 8'h09);
      chk({5'h00, mval, prev, hreq}, 8'h04);
      pins(1'b1, 1'b1, 1'b0);
      chk({4'h0, mval, mon, prev, hreq}, 8'h0F);
      wr(pll_hold_pkg::PLL_HOLD_OFS, 8'h03);
      chk({6'h00, src}, 8'h02);
      chk({6'h00, hen, hreq}, 8'h02);
      pins(1'b0, 1'b0, 1'b1);
      chk({7'h00, hreq}, 8'h01);
      wr(pll_hold_pkg::PLL_HOLD_OFS, 8'h00);
      pins(1'b0, 1'b1, 1'b0);
      chk({6'h00, hen, hreq}, 8'h00);
      $display("t_hold done");
   endtask
   // every feedback divider code
   task automatic t_fb;
      for (int i = 0; i < 4; i++)
      begin
         wr(pll_hold_pkg::ZD_FB_OFS, 8'(i << 3));
         chk({6'h00, fsel}, 8'(i));
         chk({6'h00, cfg_q.fb_sel}, 8'(i));
      end
      $display("t_fb done");
   endtask
   // status refresh and freeze
   task automatic t_stat;
      @(posedge mclk);
      live <= 8'h5A;
      repeat (3) @(posedge mclk);
      rd(pll_hold_pkg::STATUS_OFS);
      chk(v, 8'h5A);
      wr(pll_hold_pkg::PLL_HOLD_OFS, 8'h10);
      @(posedge mclk);
      live <= 8'hA5;
      repeat (3) @(posedge mclk);
      rd(pll_hold_pkg::STATUS_OFS);
      chk(v, 8'h5A);
      $display("t_stat done");
   endtask
   // reset in mid-run clears the holdover bits
   task automatic t_rst;
      wr(pll_hold_pkg::PLL_HOLD_OFS, 8'h21);
      @(posedge mclk);
      srst <= 1'b1;
      @(posedge mclk);
      srst <= 1'b0;
      #1;
      chk({6'h00, hen, dbl}, 8'h00);
      rd(pll_hold_pkg::PLL_HOLD_OFS);
      chk(v, 8'h00);
      $display("t_rst done");
   endtask
   task automatic final_report;
      $display("comparisons %0d mismatches %0d", tests_run, n_errors);
      if (n_errors == 0 && tests_run > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   // main sequence
   initial
   begin
      repeat (16) @(posedge mclk);
      srst <= 1'b0;
      t_regs();
      t_hold();
      t_fb();
      t_stat();
      t_rst();
      final_report();
   end
   // watchdog
   initial
   begin
      #20us;
      n_errors++;
      final_report();
   end
endmodule
